/* inc/qtsm_params.svh */
// Constants for the quadrature/timer/SPI pin multiplexer
`ifndef QTSM_PARAMS_SVH
`define QTSM_PARAMS_SVH
// Number of multiplexed pins
`define QTSM_PIN_COUNT     2
// Pull-up enable bit for the first pin
`define QTSM_PUR_BIT_PIN0  0
// Pull-up enable bit for the second pin
`define QTSM_PUR_BIT_PIN1  1
// Pull-up state forced during reset
`define QTSM_PULLUP_RESET  1'b1
// Level seen on a floating, pulled-up pad
`define QTSM_PAD_IDLE      1'b1
`endif

/* inc/qtsm_pkg.sv */
// Types shared by the quadrature/timer/SPI pin multiplexer
package qtsm_pkg;
  // Function currently given to one pin
  typedef enum logic [2:0] {
    QTSM_FN_NONE,
    QTSM_FN_DECODER,
    QTSM_FN_TIMER,
    QTSM_FN_SPI,
    QTSM_FN_GPIO
  } qtsm_func_t;
endpackage

/* hdl/qtsm_pin_mux.sv */
// Pin multiplexer for decoder phase, timer B, SPI port 2 and port C lines
//
// Contract
// - Full variant: first pin resets to phase A.
// - Full variant: second pin resets to phase B.
// - Reduced variant: pins unassigned until software configures.
// - Phase A alt bit routes first pin to SPI clock.
// - Phase B alt bit routes second pin to MOSI.
// - Pull-up bit 0 clear disables first pin pull-up.
// - Pull-up bit 1 clear disables second pin pull-up.
// - SPI clock: output as master, input as slave.
// - MOSI leads sampling edge half cycle; master drives.
// - Port C lines have individually programmable direction.
// - Pins also offer timer B channels 0, 1.
`timescale 1ns/1ps
`include "qtsm_params.svh"

module qtsm_pin_mux #(
  parameter bit HAS_DECODER = 1'b1            // Full variant carries the quadrature decoder
) (
  // Clock and reset
  input  wire logic                 clk_sys_in,
  input  wire logic                 rstn_in,
  // Pads (index 0 = first pin, index 1 = second pin)
  input  wire logic [1:0]           pad_in,
  output logic      [1:0]           pad_out,
  output logic      [1:0]           pad_oe_out,
  output logic      [1:0]           pad_pullup_out,
  // Configuration bits
  input  wire logic                 phase_a_alt_select_in,
  input  wire logic                 phase_b_alt_select_in,
  input  wire logic [1:0]           port_c_pullup_enable_reg_in,
  input  wire logic [1:0]           gpio_select_in,
  input  wire logic [1:0]           timer_select_in,
  input  wire logic [1:0]           config_load_in,
  // Decoder channel one
  output logic                      decoder1_phase_a_in_out,
  output logic                      decoder1_phase_b_in_out,
  // Timer B channels 0 and 1
  input  wire logic [1:0]           timer_b_chan_drive_in,
  input  wire logic [1:0]           timer_b_chan_oe_in,
  output logic      [1:0]           timer_b_chan_pin_out,
  // SPI port 2
  input  wire logic                 spi_port2_master_mode_in,
  input  wire logic                 spi_port2_serial_clock_in,
  input  wire logic                 spi_port2_master_out_in,
  output logic                      spi_port2_serial_clock_out,
  output logic                      spi_port2_master_out_out,
  // Port C lines 0 and 1
  input  wire logic [1:0]           port_c_line_dir_in,
  input  wire logic [1:0]           port_c_line_drive_in,
  output logic      [1:0]           port_c_line_out,
  // Function status
  output qtsm_pkg::qtsm_func_t      pin0_function_out,
  output qtsm_pkg::qtsm_func_t      pin1_function_out
);
  import qtsm_pkg::*;

  // ==========================================================================
  // Per-pin state
  // ==========================================================================
  logic [1:0]  sync1_q,  sync1_d;     // First synchroniser stage
  logic [1:0]  sync2_q,  sync2_d;     // Second stage
  logic [1:0]  sync3_q,  sync3_d;     // Third stage
  logic [1:0]  filt_q,   filt_d;      // Accepted pad level
  logic [1:0]  cfg_q,    cfg_d;       // Pin has been configured
  qtsm_func_t  func_q [2];            // Active function
  qtsm_func_t  func_d [2];            // Next function
  logic [1:0]  out_q,    out_d;       // Pad drive value
  logic [1:0]  oe_q,     oe_d;        // Pad output enable
  logic [1:0]  pu_q,     pu_d;        // Pad pull-up
  logic [1:0]  tmr_q,    tmr_d;       // Level to timer channel
  logic [1:0]  gpio_q,   gpio_d;      // Level to port C line
  logic [1:0]  dec_q,    dec_d;       // Level to decoder phase
  logic [1:0]  spi_q,    spi_d;       // Level to SPI slave input
  logic [1:0]  alt_sel;               // Alternate select per pin
  logic [1:0]  spi_val;               // SPI master value per pin

  // Pin 0 carries the SPI clock, pin 1 the master-out data
  assign alt_sel = {phase_b_alt_select_in, phase_a_alt_select_in};
  assign spi_val = {spi_port2_master_out_in, spi_port2_serial_clock_in};

  // ==========================================================================
  // Per-pin multiplexer
  // ==========================================================================
  for (genvar i = 0; i < `QTSM_PIN_COUNT; i++) begin : g_pin
    localparam int PUR_BIT = (i == 0) ? `QTSM_PUR_BIT_PIN0 : `QTSM_PUR_BIT_PIN1;

    // Next-state logic for one pin
    always_comb begin
      // Stage one feeds stage two only; a change counts once two and three agree
      sync1_d[i] = pad_in[i];
      sync2_d[i] = sync1_q[i];
      sync3_d[i] = sync2_q[i];
      filt_d[i]  = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : filt_q[i];
      // Reduced variant stays unassigned until a load strobe arrives
      cfg_d[i]   = cfg_q[i] | config_load_in[i];
      if (!cfg_d[i]) begin
        func_d[i] = QTSM_FN_NONE;
      end else if (gpio_select_in[i]) begin
        func_d[i] = QTSM_FN_GPIO;
      end else if (alt_sel[i]) begin
        func_d[i] = QTSM_FN_SPI;
      end else if (timer_select_in[i] || !HAS_DECODER) begin
        // Without a decoder the timer is the only non-SPI peripheral left
        func_d[i] = QTSM_FN_TIMER;
      end else begin
        func_d[i] = QTSM_FN_DECODER;
      end
      // Pad drive follows the chosen function
      case (func_d[i])
        QTSM_FN_TIMER: begin
          oe_d[i]  = timer_b_chan_oe_in[i];
          out_d[i] = timer_b_chan_drive_in[i];
        end
        QTSM_FN_SPI: begin
          // Master drives; the SPI port itself sets up MOSI half a cycle early
          oe_d[i]  = spi_port2_master_mode_in;
          out_d[i] = spi_val[i];
        end
        QTSM_FN_GPIO: begin
          oe_d[i]  = port_c_line_dir_in[i];
          out_d[i] = port_c_line_drive_in[i];
        end
        default: begin
          // Decoder input or unassigned: pad stays an input
          oe_d[i]  = 1'b0;
          out_d[i] = 1'b0;
        end
      endcase
      pu_d[i]   = port_c_pullup_enable_reg_in[PUR_BIT];
      // Inbound levels go only to the function that owns the pin
      dec_d[i]  = (func_q[i] == QTSM_FN_DECODER) ? filt_q[i] : `QTSM_PAD_IDLE;
      tmr_d[i]  = (func_q[i] == QTSM_FN_TIMER) ? filt_q[i] : 1'b0;
      gpio_d[i] = (func_q[i] == QTSM_FN_GPIO) ? filt_q[i] : 1'b0;
      spi_d[i]  = (func_q[i] == QTSM_FN_SPI && !spi_port2_master_mode_in) ? filt_q[i] : 1'b0;
    end

    // Registers for one pin; reset leaves an input with pull-up
    always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
        sync1_q[i] <= `QTSM_PAD_IDLE;
        sync2_q[i] <= `QTSM_PAD_IDLE;
        sync3_q[i] <= `QTSM_PAD_IDLE;
        filt_q[i]  <= `QTSM_PAD_IDLE;
        cfg_q[i]   <= HAS_DECODER;
        func_q[i]  <= HAS_DECODER ? QTSM_FN_DECODER : QTSM_FN_NONE;
        oe_q[i]    <= 1'b0;
        out_q[i]   <= 1'b0;
        pu_q[i]    <= `QTSM_PULLUP_RESET;
        dec_q[i]   <= `QTSM_PAD_IDLE;
        tmr_q[i]   <= 1'b0;
        gpio_q[i]  <= 1'b0;
        spi_q[i]   <= 1'b0;
      end else begin
        sync1_q[i] <= sync1_d[i];
        sync2_q[i] <= sync2_d[i];
        sync3_q[i] <= sync3_d[i];
        filt_q[i]  <= filt_d[i];
        cfg_q[i]   <= cfg_d[i];
        func_q[i]  <= func_d[i];
        oe_q[i]    <= oe_d[i];
        out_q[i]   <= out_d[i];
        pu_q[i]    <= pu_d[i];
        dec_q[i]   <= dec_d[i];
        tmr_q[i]   <= tmr_d[i];
        gpio_q[i]  <= gpio_d[i];
        spi_q[i]   <= spi_d[i];
      end
    end
  end

  // ==========================================================================
  // Outputs, all straight from flip-flops
  // ==========================================================================
  assign pad_out                    = out_q;
  assign pad_oe_out                 = oe_q;
  assign pad_pullup_out             = pu_q;
  assign decoder1_phase_a_in_out    = dec_q[0];
  assign decoder1_phase_b_in_out    = dec_q[1];
  assign timer_b_chan_pin_out       = tmr_q;
  assign spi_port2_serial_clock_out = spi_q[0];
  assign spi_port2_master_out_out   = spi_q[1];
  assign port_c_line_out            = gpio_q;
  assign pin0_function_out          = func_q[0];
  assign pin1_function_out          = func_q[1];

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_reset_default_a;
    @(posedge clk_sys_in) (HAS_DECODER && !rstn_in) |=> (func_q[0] == QTSM_FN_DECODER);
  endproperty
  a_reset_default_a: assert property (p_reset_default_a) else $error("pin0 not decoder after reset");

  property p_reset_default_b;
    @(posedge clk_sys_in) (HAS_DECODER && !rstn_in) |=> (func_q[1] == QTSM_FN_DECODER);
  endproperty
  a_reset_default_b: assert property (p_reset_default_b) else $error("pin1 not decoder after reset");

  property p_reduced_unassigned;
    @(posedge clk_sys_in) (!HAS_DECODER && !rstn_in) ##1 (rstn_in && !config_load_in[0])
      |=> (func_q[0] == QTSM_FN_NONE) && !oe_q[0];
  endproperty
  a_reduced_unassigned: assert property (p_reduced_unassigned) else $error("reduced pin0 assigned");

  property p_alt_a_spi;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (cfg_q[0] && phase_a_alt_select_in && !gpio_select_in[0]) |=> (func_q[0] == QTSM_FN_SPI);
  endproperty
  a_alt_a_spi: assert property (p_alt_a_spi) else $error("pin0 not routed to spi clock");

  property p_alt_b_spi;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (cfg_q[1] && phase_b_alt_select_in && !gpio_select_in[1]) |=> (func_q[1] == QTSM_FN_SPI);
  endproperty
  a_alt_b_spi: assert property (p_alt_b_spi) else $error("pin1 not routed to mosi");

  property p_reset_input_pullup;
    @(posedge clk_sys_in) !rstn_in |=> (pu_q == 2'h3) && (oe_q == 2'h0);
  endproperty
  a_reset_input_pullup: assert property (p_reset_input_pullup) else $error("pads not pulled-up inputs");

  property p_pullup0_off;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      !port_c_pullup_enable_reg_in[`QTSM_PUR_BIT_PIN0] ##1 rstn_in |-> !pad_pullup_out[0];
  endproperty
  a_pullup0_off: assert property (p_pullup0_off) else $error("pin0 pull-up stuck on");

  property p_pullup1_off;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      !port_c_pullup_enable_reg_in[`QTSM_PUR_BIT_PIN1] ##1 rstn_in |-> !pad_pullup_out[1];
  endproperty
  a_pullup1_off: assert property (p_pullup1_off) else $error("pin1 pull-up stuck on");

  property p_sclk_dir;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      ($past(rstn_in) && func_q[0] == QTSM_FN_SPI)
      |-> (oe_q[0] == $past(spi_port2_master_mode_in)) && (out_q[0] == $past(spi_port2_serial_clock_in));
  endproperty
  a_sclk_dir: assert property (p_sclk_dir) else $error("spi clock pad direction wrong");

  property p_mosi_dir;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      ($past(rstn_in) && func_q[1] == QTSM_FN_SPI)
      |-> (oe_q[1] == $past(spi_port2_master_mode_in)) && (out_q[1] == $past(spi_port2_master_out_in));
  endproperty
  a_mosi_dir: assert property (p_mosi_dir) else $error("mosi pad direction wrong");

  property p_gpio_dir;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      ($past(rstn_in) && func_q[1] == QTSM_FN_GPIO) |-> (oe_q[1] == $past(port_c_line_dir_in[1]));
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) else $error("port c direction not followed");

  property p_timer_drive;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      ($past(rstn_in) && func_q[0] == QTSM_FN_TIMER) |-> (oe_q[0] == $past(timer_b_chan_oe_in[0]));
  endproperty
  a_timer_drive: assert property (p_timer_drive) else $error("timer channel 0 enable not followed");

  property p_no_alt_no_spi;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (cfg_q[0] && !phase_a_alt_select_in && !gpio_select_in[0]) |=> (func_q[0] != QTSM_FN_SPI);
  endproperty
  a_no_alt_no_spi: assert property (p_no_alt_no_spi) else $error("pin0 on spi without alt bit");

endmodule

/* bench/qtsm_pad_partner.sv */
// Pad model standing for the encoder, SPI partner or port C load on one pin
`timescale 1ns/1ps

module qtsm_pad_partner (
  // Clock
  input  wire logic clk_sys_in,
  // Device side of the pad
  input  wire logic dev_oe_in,
  input  wire logic dev_val_in,
  input  wire logic pull_in,
  // Far side drive
  input  wire logic ext_oe_in,
  input  wire logic ext_val_in,
  // Resolved pad level
  output logic      pad_out
);
  logic last_q;  // Last resolved level, used to make an undriven pad wander

  // =========================================
  // Wire resolution
  // Device drive first, then far side, then pull-up.
  // A floating pad shows the inverse of its last level, so a missing drive never reads as a lucky match.
  always_comb begin
    if (dev_oe_in) begin
      pad_out = dev_val_in;
    end else if (ext_oe_in) begin
      pad_out = ext_val_in;  // Far side acts as master or encoder
    end else if (pull_in) begin
      pad_out = 1'b1;
    end else begin
      pad_out = ~last_q;
    end
  end

  // Remember the level for the floating case
  always_ff @(posedge clk_sys_in) begin
    last_q <= pad_out;
  end
endmodule

/* bench/qtsm_pin_mux_bench.sv */
// Self-checking bench for the decoder/timer/SPI/port C pin multiplexer
`timescale 1ns/1ps

module qtsm_pin_mux_bench;
  import qtsm_pkg::*;
  // =========================================
  // Stimulus row: inputs, far-side drive, expected outputs
  typedef struct packed {
    logic alt_a, alt_b; logic [1:0] gsel, tsel; logic mst, sck, mo;
    logic [1:0] gdir, gdrv, tdrv, toe, pur, xoe, xval;
    qtsm_func_t f0, f1; logic [1:0] oe, out, pu;
    logic [7:0] inb;  // {dec a, dec b, timer 1, timer 0, sclk, mosi, port c 1, port c 0}
  } qtsm_row_t;

  localparam qtsm_func_t DE = QTSM_FN_DECODER;
  localparam qtsm_func_t SP = QTSM_FN_SPI;
  localparam qtsm_func_t GP = QTSM_FN_GPIO;
  localparam qtsm_func_t TI = QTSM_FN_TIMER;

  logic       clk_sys_in;   // 50 MHz system clock
  logic       rstn_in;      // Synchronous reset, active low
  logic [1:0] cfg_load;     // Configuration strobe for the reduced variant
  logic [1:0] pad, oe, dout, pu, tb_pin, gp_pin;
  logic       dec_a, dec_b, sck_o, mo_o;
  qtsm_func_t f0, f1, rf0, rf1;
  qtsm_row_t  cur;          // Row now applied
  qtsm_row_t  rows [10];
  int         error_cnt, checks_done;

  // =========================================
  // Clock, design instances, pad models
  always #10 clk_sys_in = ~clk_sys_in;

  qtsm_pin_mux qtsm_pin_mux_inst (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .pad_in(pad), .pad_out(dout),
    .pad_oe_out(oe), .pad_pullup_out(pu), .phase_a_alt_select_in(cur.alt_a), .phase_b_alt_select_in(cur.alt_b),
    .port_c_pullup_enable_reg_in(cur.pur), .gpio_select_in(cur.gsel), .timer_select_in(cur.tsel),
    .config_load_in(cfg_load), .decoder1_phase_a_in_out(dec_a), .decoder1_phase_b_in_out(dec_b),
    .timer_b_chan_drive_in(cur.tdrv), .timer_b_chan_oe_in(cur.toe), .timer_b_chan_pin_out(tb_pin),
    .spi_port2_master_mode_in(cur.mst), .spi_port2_serial_clock_in(cur.sck), .spi_port2_master_out_in(cur.mo),
    .spi_port2_serial_clock_out(sck_o), .spi_port2_master_out_out(mo_o), .port_c_line_dir_in(cur.gdir),
    .port_c_line_drive_in(cur.gdrv), .port_c_line_out(gp_pin), .pin0_function_out(f0), .pin1_function_out(f1));

  // Reduced variant shares every input; only its function status is watched
  qtsm_pin_mux #(.HAS_DECODER(1'b0)) qtsm_pin_mux_red_inst (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .pad_in(pad), .pad_out(), .pad_oe_out(), .pad_pullup_out(), .phase_a_alt_select_in(cur.alt_a),
    .phase_b_alt_select_in(cur.alt_b), .port_c_pullup_enable_reg_in(cur.pur), .gpio_select_in(cur.gsel),
    .timer_select_in(cur.tsel), .config_load_in(cfg_load), .decoder1_phase_a_in_out(),
    .decoder1_phase_b_in_out(), .timer_b_chan_drive_in(cur.tdrv), .timer_b_chan_oe_in(cur.toe),
    .timer_b_chan_pin_out(), .spi_port2_master_mode_in(cur.mst), .spi_port2_serial_clock_in(cur.sck),
    .spi_port2_master_out_in(cur.mo), .spi_port2_serial_clock_out(), .spi_port2_master_out_out(),
    .port_c_line_dir_in(cur.gdir), .port_c_line_drive_in(cur.gdrv), .port_c_line_out(),
    .pin0_function_out(rf0), .pin1_function_out(rf1));

  for (genvar i = 0; i < 2; i++) begin : g_pad
    qtsm_pad_partner qtsm_pad_partner_inst (.clk_sys_in(clk_sys_in), .dev_oe_in(oe[i]), .dev_val_in(dout[i]),
      .pull_in(pu[i]), .ext_oe_in(cur.xoe[i]), .ext_val_in(cur.xval[i]), .pad_out(pad[i]));
  end

  // =========================================
  // Comparison and verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog: the whole run is far shorter than this
  initial begin
    repeat (3000) @(posedge clk_sys_in);
    error_cnt++;
    close_out();
  end

  // =========================================
  // Main sequence
  initial begin
    clk_sys_in = 1'b0; rstn_in = 1'b0; cfg_load = 2'b00; cur = '0;
    error_cnt = 0; checks_done = 0;
    rows[0] = '{1'b0,1'b0,2'b00,2'b00,1'b0,1'b0,1'b0,2'b00,2'b00,2'b00,2'b00,2'b11,2'b11,2'b10,DE,DE,2'b00,2'b00,2'b11,8'h40};
    rows[1] = '{1'b1,1'b0,2'b00,2'b00,1'b1,1'b1,1'b0,2'b00,2'b00,2'b00,2'b00,2'b11,2'b10,2'b00,SP,DE,2'b01,2'b01,2'b11,8'h80};
    rows[2] = '{1'b0,1'b1,2'b00,2'b00,1'b1,1'b0,1'b1,2'b00,2'b00,2'b00,2'b00,2'b11,2'b01,2'b00,DE,SP,2'b10,2'b10,2'b11,8'h40};
    rows[3] = '{1'b1,1'b1,2'b00,2'b00,1'b0,1'b0,1'b0,2'b00,2'b00,2'b00,2'b00,2'b11,2'b11,2'b11,SP,SP,2'b00,2'b00,2'b11,8'hcc};
    rows[4] = '{1'b1,1'b1,2'b11,2'b00,1'b0,1'b0,1'b0,2'b01,2'b11,2'b00,2'b00,2'b11,2'b10,2'b00,GP,GP,2'b01,2'b01,2'b11,8'hc1};
    rows[5] = '{1'b0,1'b0,2'b11,2'b00,1'b0,1'b0,1'b0,2'b10,2'b10,2'b00,2'b00,2'b11,2'b01,2'b00,GP,GP,2'b10,2'b10,2'b11,8'hc2};
    rows[6] = '{1'b0,1'b0,2'b00,2'b11,1'b0,1'b0,1'b0,2'b00,2'b00,2'b10,2'b11,2'b11,2'b00,2'b00,TI,TI,2'b11,2'b10,2'b11,8'he0};
    rows[7] = '{1'b0,1'b0,2'b00,2'b11,1'b0,1'b0,1'b0,2'b00,2'b00,2'b00,2'b00,2'b11,2'b11,2'b01,TI,TI,2'b00,2'b00,2'b11,8'hd0};
    rows[8] = '{1'b0,1'b0,2'b00,2'b00,1'b0,1'b0,1'b0,2'b00,2'b00,2'b00,2'b00,2'b10,2'b11,2'b11,DE,DE,2'b00,2'b00,2'b10,8'hc0};
    rows[9] = '{1'b0,1'b0,2'b00,2'b00,1'b0,1'b0,1'b0,2'b00,2'b00,2'b00,2'b00,2'b01,2'b11,2'b00,DE,DE,2'b00,2'b00,2'b01,8'h00};
    repeat (5) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    // Table of ordinary cases; eight edges covers the five-edge inbound path plus the function change
    foreach (rows[i]) begin
      @(posedge clk_sys_in);
      cur <= rows[i];
      repeat (8) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      check({2'b00, f0, f1}, {2'b00, rows[i].f0, rows[i].f1});
      check({4'h0, oe, dout & oe}, {4'h0, rows[i].oe, rows[i].out});
      check({6'h00, pu}, {6'h00, rows[i].pu});
      check({dec_a, dec_b, tb_pin, sck_o, mo_o, gp_pin}, rows[i].inb);
    end
    // Reset in mid-run while pin 0 is driven as SPI master clock
    @(posedge clk_sys_in);
    cur <= rows[1];
    repeat (4) @(posedge clk_sys_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    check({4'h0, oe, pu}, 8'h03);
    check({2'b00, f0, f1}, {2'b00, DE, DE});
    check({2'b00, rf0, rf1}, {2'b00, QTSM_FN_NONE, QTSM_FN_NONE});
    @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    check({2'b00, f0, rf0}, {2'b00, SP, QTSM_FN_NONE});
    // Reduced variant: configure only the first pin, alternate bits clear
    @(posedge clk_sys_in);
    cur <= rows[0];
    cfg_load <= 2'b01;
    @(posedge clk_sys_in);
    cfg_load <= 2'b00;
    repeat (3) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    check({2'b00, rf0, rf1}, {2'b00, TI, QTSM_FN_NONE});
    close_out();
  end
endmodule
